// ### logic/kbc_watchdog.sv
// watchdog timer of the keyboard controller core
//
// Behaviour
// - 8-bit down counter behind 9-bit prescaler
// - prescaler runs from always-on 32 khz tick
// - decrement once per 512 slow ticks
// - underflow raises main plane power-on reset
// - counting continues while the core idles
// - inactive after reset, started by run bit
// - every power-on reset clears run bit
// - counter writes need unlock; load clears it
// - reload 01h shortest, ffh longest interval
// - loading 00h clears run and unlock
// - prescaler restarts on every counter load
// - counter at 7f38, resets to ffh
// - control at 7f37, resets 00h, bits1:0 writable
`timescale 1ns/1ps
module kbc_watchdog #(
   parameter int unsigned TICK_LAST = guard_pkg::SLOW_DIV - 1
) (
   input  wire logic        sys_clk_in,
   input  wire logic        srst_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        core_idle_in,
   output logic [7:0]       reg_rdata_out,
   output logic             main_plane_power_on_reset_out,
   output logic             guard_run_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_RESET} rst_state_t;

   guard_tick_if tk ();

   logic [7:0] guard_countdown_reg;
   logic [7:0] guard_countdown_next;
   logic       guard_run_reg;
   logic       reload_unlock_reg;
   logic [2:0] pulse_reg;
   rst_state_t state_reg;

   // register decode
   wire sel_ctrl  = (reg_addr_in == guard_pkg::CTRL_ADDR);
   wire sel_count = (reg_addr_in == guard_pkg::COUNT_ADDR);
   wire wr_ctrl   = reg_wr_in && sel_ctrl;
   wire load      = reg_wr_in && sel_count && reload_unlock_reg;
   wire load_off  = load && (reg_wdata_in == guard_pkg::COUNT_DISABLE);
   wire step      = tk.step;
   // underflow happens when a step arrives at count 01h, so 01h gives one step
   wire underflow = guard_run_reg && step && (guard_countdown_reg == guard_pkg::COUNT_LAST);
   wire fire      = underflow && !load;
   wire in_reset  = (state_reg == ST_RESET);

   // the power-on reset it raises also clears the block itself
   wire local_rst = srst_in || in_reset;

   assign tk.clear = load;

   slow_tick_gen #(.LAST(TICK_LAST)) u_tick (
      .sys_clk_in (sys_clk_in),
      .srst_in    (local_rst),
      .tk         (tk)
   );

   guard_prescaler #(.W(guard_pkg::PRESCALE_W)) u_pre (
      .sys_clk_in (sys_clk_in),
      .srst_in    (local_rst),
      .run_in     (guard_run_reg),
      .tk         (tk)
   );

   // idle state of the core does not gate the count
   wire unused_idle = core_idle_in;

   always_comb begin
      guard_countdown_next = guard_countdown_reg;
      if (load) guard_countdown_next = reg_wdata_in;
      else if (guard_run_reg && step) guard_countdown_next = guard_countdown_reg - 8'h01;
   end

   always_ff @(posedge sys_clk_in) begin
      if (local_rst) guard_countdown_reg <= guard_pkg::COUNT_RESET;
      else guard_countdown_reg <= guard_countdown_next;
   end

   always_ff @(posedge sys_clk_in) begin
      if (local_rst) guard_run_reg <= 1'b0;
      else if (load_off) guard_run_reg <= 1'b0;
      else if (wr_ctrl) guard_run_reg <= reg_wdata_in[guard_pkg::RUN_BIT];
   end

   always_ff @(posedge sys_clk_in) begin
      if (local_rst) reload_unlock_reg <= 1'b0;
      else if (load) reload_unlock_reg <= 1'b0;
      else if (wr_ctrl) reload_unlock_reg <= reg_wdata_in[guard_pkg::UNLOCK_BIT];
   end

   // reset pulse sequencer
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_reg <= ST_IDLE;
         pulse_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (fire) begin
                  state_reg <= ST_RESET;
                  pulse_reg <= 3'(guard_pkg::RESET_PULSE_CYC - 1);
               end
            end
            ST_RESET: begin
               if (pulse_reg == 3'h0) state_reg <= ST_IDLE;
               else pulse_reg <= pulse_reg - 3'h1;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) main_plane_power_on_reset_out <= 1'b0;
      else main_plane_power_on_reset_out <= fire || (in_reset && pulse_reg != 3'h0);
   end

   always_ff @(posedge sys_clk_in) begin
      if (local_rst) guard_run_out <= 1'b0;
      else guard_run_out <= guard_run_reg;
   end

   // read data, reserved bits read zero
   wire [7:0] ctrl_view = {6'h00, guard_run_reg, reload_unlock_reg};
   wire [7:0] rd_mux = sel_ctrl ? ctrl_view : (sel_count ? guard_countdown_reg : 8'h00);

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) reg_rdata_out <= 8'h00;
      else if (reg_rd_in) reg_rdata_out <= rd_mux;
   end
endmodule : kbc_watchdog

// ### inc/guard_pkg.sv
// constants for the keyboard controller watchdog
package guard_pkg;
   localparam int unsigned        ADDR_W         = 16;
   localparam logic [15:0]        CTRL_ADDR      = 16'h7f37;
   localparam logic [15:0]        COUNT_ADDR     = 16'h7f38;
   localparam logic [7:0]         CTRL_RESET     = 8'h00;
   localparam logic [7:0]         COUNT_RESET    = 8'hff;
   localparam int unsigned        RUN_BIT        = 1;
   localparam int unsigned        UNLOCK_BIT     = 0;
   localparam int unsigned        COUNT_W        = 8;
   localparam int unsigned        PRESCALE_W     = 9;
   localparam logic [8:0]         PRESCALE_LAST  = 9'h1ff;
   localparam logic [7:0]         COUNT_DISABLE  = 8'h00;
   localparam logic [7:0]         COUNT_LAST     = 8'h01;
   localparam int unsigned        SLOW_HZ        = 32768;
   localparam int unsigned        SYS_HZ         = 100000000;
   localparam int unsigned        SLOW_DIV       = SYS_HZ / SLOW_HZ;
   localparam logic [11:0]        SLOW_DIV_LAST  = 12'(SLOW_DIV - 1);
   localparam int unsigned        RESET_PULSE_CYC = 4;
endpackage : guard_pkg

// ### inc/guard_tick_if.sv
// carries the slow tick between the watchdog modules
`timescale 1ns/1ps
interface guard_tick_if;
   logic tick;
   logic clear;
   logic step;
   modport src (output tick, input clear);
   modport pre (input tick, input clear, output step);
endinterface : guard_tick_if

// ### logic/slow_tick_gen.sv
// divides the system clock to a 32 khz enable pulse
`timescale 1ns/1ps
module slow_tick_gen #(
   parameter int unsigned LAST = guard_pkg::SLOW_DIV - 1
) (
   input  wire logic   sys_clk_in,
   input  wire logic   srst_in,
   guard_tick_if.src   tk
);
   logic [11:0] div_reg;
   wire         div_end = (div_reg == 12'(LAST));
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) div_reg <= 12'h000;
      else div_reg <= div_end ? 12'h000 : div_reg + 12'h001;
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) tk.tick <= 1'b0;
      else tk.tick <= div_end;
   end
endmodule : slow_tick_gen

// ### logic/guard_prescaler.sv
// nine-bit prescaler giving one step per 512 slow ticks
`timescale 1ns/1ps
module guard_prescaler #(
   parameter int unsigned W = guard_pkg::PRESCALE_W
) (
   input  wire logic   sys_clk_in,
   input  wire logic   srst_in,
   input  wire logic   run_in,
   guard_tick_if.pre   tk
);
   logic [W-1:0] pre_reg;
   wire          wrap = &pre_reg;
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || tk.clear) pre_reg <= '0;
      else if (run_in && tk.tick) pre_reg <= pre_reg + 1'b1;
   end
   assign tk.step = run_in && tk.tick && wrap && !tk.clear;
endmodule : guard_prescaler

// ### verif/kbc_watchdog_asserts.sv
// port assertions for the watchdog
`timescale 1ns/1ps
module kbc_watchdog_asserts (
   input wire logic        sys_clk_in,
   input wire logic        srst_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        main_plane_power_on_reset_out,
   input wire logic        guard_run_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   wire ctrl_hit = reg_addr_in == guard_pkg::CTRL_ADDR;
   wire ctrl_wr  = reg_wr_in && ctrl_hit;
   wire ctrl_rd  = reg_rd_in && ctrl_hit;
   wire odd_rd   = reg_rd_in && !ctrl_hit && reg_addr_in != guard_pkg::COUNT_ADDR;
   a_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out)) else $error("rdata moved");
   a_resv_zero: assert property ($past(ctrl_rd) |-> reg_rdata_out[7:2] == 6'h00) else $error("resv");
   a_run_view: assert property ($past(ctrl_rd) |-> reg_rdata_out[1] == guard_run_out) else $error("run");
   a_unmapped_zero: assert property ($past(odd_rd) |-> reg_rdata_out == 8'h00) else $error("odd");
   a_run_start: assert property (ctrl_wr && reg_wdata_in[1] |-> ##2 guard_run_out) else $error("start");
   a_run_stop: assert property (ctrl_wr && !reg_wdata_in[1] |-> ##2 !guard_run_out) else $error("stop");
   a_run_cause: assert property (!$stable(guard_run_out) |-> $past(reg_wr_in, 2)
      || $past(main_plane_power_on_reset_out) || $past(srst_in)) else $error("cause");
   a_pulse_len: assert property ($rose(main_plane_power_on_reset_out) |-> main_plane_power_on_reset_out[*4]
      ##1 !main_plane_power_on_reset_out) else $error("pulse");
   cover property (ctrl_wr && reg_wdata_in[1]);
   cover property ($past(odd_rd));
   cover property ($fell(guard_run_out));
   cover property ($rose(main_plane_power_on_reset_out));
endmodule : kbc_watchdog_asserts
bind kbc_watchdog kbc_watchdog_asserts u_kbc_watchdog_asserts (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
   .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .main_plane_power_on_reset_out(main_plane_power_on_reset_out),
   .guard_run_out(guard_run_out));

// ### verif/fw_model.sv
// firmware model on the register space
`timescale 1ns/1ps
module fw_model (
   input  wire logic        sys_clk_in,
   input  wire logic [7:0]  rdata_in,
   output logic [15:0]      addr_out = 16'h0000,
   output logic             wr_out = 1'b0,
   output logic             rd_out = 1'b0,
   output logic [7:0]       wdata_out = 8'h00
);
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge sys_clk_in);
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge sys_clk_in);
      rd_out = 1'b0;
      addr_out = ~a;
      d = rdata_in;
   endtask : rd
   task automatic reload(input logic [7:0] v);
      wr(guard_pkg::CTRL_ADDR, 8'h03);
      wr(guard_pkg::COUNT_ADDR, v);
   endtask : reload
endmodule : fw_model

// ### verif/tb_kbc_watchdog.sv
// bench for the watchdog
`timescale 1ns/1ps
module tb_kbc_watchdog;
   logic        sys_clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        idle = 1'b0;
   logic [15:0] addr;
   logic        wr;
   logic        rd;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [7:0]  v;
   logic        run;
   logic        por;
   int          n;
   int          bad_count = 0;
   int          check_count = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   fw_model u_fw_model (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
      .wdata_out(wdata));
   kbc_watchdog #(.TICK_LAST(1)) u_kbc_watchdog (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .core_idle_in(idle), .reg_rdata_out(rdata),
      .main_plane_power_on_reset_out(por), .guard_run_out(run));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      u_fw_model.rd(a, v);
      check("reg", v, exp);
   endtask : rd_chk
   task automatic complete_run;
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (100000) @(posedge sys_clk_in);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (16) @(negedge sys_clk_in);
      srst_in = 1'b0;
      rd_chk(guard_pkg::CTRL_ADDR, 8'h00);
      rd_chk(guard_pkg::COUNT_ADDR, 8'hff);
      check("run", {7'h00, run}, 8'h00);
      u_fw_model.wr(guard_pkg::COUNT_ADDR, 8'h20);
      rd_chk(guard_pkg::COUNT_ADDR, 8'hff);
      u_fw_model.wr(guard_pkg::CTRL_ADDR, 8'hfd);
      rd_chk(guard_pkg::CTRL_ADDR, 8'h01);
      u_fw_model.wr(guard_pkg::COUNT_ADDR, 8'h20);
      rd_chk(guard_pkg::COUNT_ADDR, 8'h20);
      rd_chk(guard_pkg::CTRL_ADDR, 8'h00);
      repeat (4000) @(negedge sys_clk_in);
      rd_chk(guard_pkg::COUNT_ADDR, 8'h20);
      idle = 1'b1;
      u_fw_model.reload(8'h01);
      rd_chk(guard_pkg::COUNT_ADDR, 8'h01);
      check("run", {7'h00, run}, 8'h01);
      u_fw_model.wr(guard_pkg::CTRL_ADDR, 8'h03);
      u_fw_model.wr(guard_pkg::COUNT_ADDR, 8'h00);
      rd_chk(guard_pkg::CTRL_ADDR, 8'h00);
      check("run", {7'h00, run}, 8'h00);
      u_fw_model.reload(8'h02);
      n = 0;
      while (!por && n < 3000) begin
         @(negedge sys_clk_in);
         n++;
      end
      check("por_time", 8'(n >= 2040 && n <= 2056), 8'h01);
      n = 0;
      while (por && n < 10) begin
         @(negedge sys_clk_in);
         n++;
      end
      check("por_len", 8'(n), 8'h04);
      rd_chk(guard_pkg::COUNT_ADDR, 8'hff);
      rd_chk(guard_pkg::CTRL_ADDR, 8'h00);
      check("run", {7'h00, run}, 8'h00);
      u_fw_model.wr(guard_pkg::CTRL_ADDR, 8'h02);
      @(negedge sys_clk_in) srst_in = 1'b1;
      @(negedge sys_clk_in) srst_in = 1'b0;
      rd_chk(guard_pkg::CTRL_ADDR, 8'h00);
      rd_chk(16'h7f39, 8'h00);
      complete_run();
   end
endmodule : tb_kbc_watchdog
